// ### core/t1_yellow_blue_alarm_detect.sv
// Yellow and blue alarm detector for T1/J1 receive lines with APB access.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// RULE1: T1 SF: watch bit 2 every channel.
// RULE2: T1 ESF: use data link, N windows.
// RULE3: T1 DM: under four Y ones declares.
// RULE4: T1 DM: over three Y ones clears.
// RULE5: J1 SF: under four frame-12 zeros declares.
// RULE6: J1 SF: clear needs M clear windows.
// RULE7: J1 ESF: under three link zeros declares.
// RULE8: J1 ESF: over two link zeros clears.
// RULE9: Blue: under 61 zeros, N windows, declares.
// RULE10: Blue: over 60 zeros, M windows, clears.
// RULE11: Yellow declare count from 8-bit field.
// RULE12: Yellow clear count from 8-bit field.
// RULE13: T1 ESF: over seven ff00 patterns declares.
// RULE14: Status change sets W1C flag, interrupt.
// RULE15: Blue counts from two 8-bit fields.
// RULE16: Yellow evaluated only while frame aligned.
// RULE17: Fixed windows; failing window resets persistence.
// RULE18: Format change restarts yellow counting.
module t1_yellow_blue_alarm_detect #(
	parameter int WINDOW_CYCLES = alarm_pkg::WINDOW_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_data,
	input wire logic rx_fbit,
	input wire logic rx_dl,
	input wire logic [4:0] rx_chan,
	input wire logic [3:0] rx_bitnum,
	input wire logic [4:0] rx_frame,
	input wire logic rx_sync,
	output logic yellow_alarm_status,
	output logic blue_alarm_status,
	output logic irq
);
	import alarm_pkg::*;

	// Width of the window timer.
	localparam int WW = $clog2(WINDOW_CYCLES);

	// The timer needs at least two states to make a window.
	if (WINDOW_CYCLES < 2) begin : g_bad_window
		$error("WINDOW_CYCLES must be at least 2");
	end

	// State of the block, apart from the two persistence filters, in one record.
	typedef struct packed {
		logic [WW-1:0] win_cnt; // Position inside the window.
		logic win_end; // Pulse after each window boundary.
		logic yel_ok; // Aligned throughout the running window.
		logic yel_win; // Closed window is valid for yellow.
		logic yel_cond; // Closed window met yellow declare.
		logic blue_cond; // Closed window met blue declare.
		logic [7:0] yel_cnt; // Yellow event count, saturating.
		logic [7:0] blue_cnt; // Received zeros, saturating.
		logic [15:0] pat; // Recent data link bits.
		logic [2:0] fmt; // Frame format.
		logic [7:0] ydth; // Yellow declare threshold.
		logic [7:0] ycth; // Yellow clear threshold.
		logic [7:0] bdth; // Blue declare threshold.
		logic [7:0] bcth; // Blue clear threshold.
		logic [1:0] flags; // Sticky change flags.
		logic [1:0] irq_en; // Interrupt enables.
		logic [1:0] prev; // Alarm states one cycle ago.
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic setup;
	logic access;
	logic wr;
	logic fmt_wr;
	logic [1:0] clr;
	logic [1:0] set;
	logic yel_status;
	logic blue_status;

	// Saturating increment; a count stuck at the top still decides.
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction

	// Declare verdict of a finished window for the given format.
	// Every clear criterion is the exact complement of the declare one.
	function automatic logic yel_declare(input logic [2:0] f,
		input logic [7:0] c);
		logic d;
		d = 1'b0;
		case (f)
			FMT_T1_SF: d = (c == 8'h00); // RULE1
			FMT_T1_ESF: d = (c > ESF_PAT_MAX_CLEAR); // RULE2 RULE13
			FMT_T1_DM: d = (c < DM_ONES_MIN); // RULE3 RULE4
			FMT_J1_SF: d = (c < J1SF_ZEROS_MIN); // RULE5 RULE6
			FMT_J1_ESF: d = (c < J1ESF_ZEROS_MIN); // RULE7 RULE8
			default: d = 1'b0;
		endcase
		return d;
	endfunction

	// APB phase decode; pready is only ever high in the first access cycle.
	assign setup = psel && !penable;
	assign access = psel && penable && s_r.pready;
	assign wr = access && pwrite;
	// A write that really changes the format restarts yellow work.
	assign fmt_wr = wr && paddr == OFS_FORMAT && pwdata[2:0] != s_r.fmt;
	assign clr = (wr && paddr == OFS_FLAGS) ? pwdata[1:0] : 2'b00;
	assign set = {blue_status, yel_status} ^ s_r.prev;

	// Outputs straight from the state register or the filters.
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign irq = s_r.irq;
	assign yellow_alarm_status = yel_status;
	assign blue_alarm_status = blue_status;

	// Next-state logic for timer, counters, registers and bus answer.
	always_comb begin
		s_nxt = s_r;
		s_nxt.win_end = 1'b0;
		// Fixed, back-to-back windows; a bit in the last cycle belongs
		// to the next window.
		if (s_r.win_cnt == WW'(WINDOW_CYCLES - 1)) begin
			s_nxt.win_cnt = '0; // RULE17
			s_nxt.win_end = 1'b1;
			s_nxt.blue_cond = s_r.blue_cnt < BLUE_ZEROS_MIN; // RULE9 RULE10
			s_nxt.yel_cond = yel_declare(s_r.fmt, s_r.yel_cnt);
			s_nxt.yel_win = s_r.yel_ok && rx_sync; // RULE16
			s_nxt.blue_cnt = 8'h00;
			s_nxt.yel_cnt = 8'h00;
			s_nxt.yel_ok = 1'b1;
		end else begin
			s_nxt.win_cnt = s_r.win_cnt + 1'b1;
		end
		// Blue counts every received zero, framed or not.
		if (rx_valid && !rx_data) begin
			s_nxt.blue_cnt = sat_inc(s_nxt.blue_cnt); // RULE9
		end
		// Yellow only counts while aligned; a gap voids the window.
		if (!rx_sync) begin
			s_nxt.yel_ok = 1'b0; // RULE16
		end else if (rx_valid) begin
			case (s_r.fmt)
				FMT_T1_SF: begin
					if (!rx_fbit && rx_bitnum == SF_YEL_BIT && rx_data) begin
						s_nxt.yel_cnt = sat_inc(s_nxt.yel_cnt); // RULE1
					end
				end
				FMT_T1_ESF: begin
					if (rx_dl) begin
						s_nxt.pat = {s_r.pat[14:0], rx_data};
						if (s_nxt.pat == ESF_YEL_PATTERN) begin
							s_nxt.yel_cnt = sat_inc(s_nxt.yel_cnt); // RULE13
						end
					end
				end
				FMT_T1_DM: begin
					if (!rx_fbit && rx_chan == DM_YEL_CHAN
						&& rx_bitnum == DM_YEL_BIT && rx_data) begin
						s_nxt.yel_cnt = sat_inc(s_nxt.yel_cnt); // RULE3
					end
				end
				FMT_J1_SF: begin
					if (rx_fbit && rx_frame == J1SF_YEL_FRAME && !rx_data) begin
						s_nxt.yel_cnt = sat_inc(s_nxt.yel_cnt); // RULE5
					end
				end
				FMT_J1_ESF: begin
					if (rx_dl && !rx_data) begin
						s_nxt.yel_cnt = sat_inc(s_nxt.yel_cnt); // RULE7
					end
				end
				default: begin
					// Unused codes count nothing.
					s_nxt.yel_cnt = s_nxt.yel_cnt;
				end
			endcase
		end
		// Format change throws away the partial and any closing window.
		if (fmt_wr) begin
			s_nxt.yel_cnt = 8'h00; // RULE18
			s_nxt.yel_ok = 1'b0;
			s_nxt.yel_win = 1'b0;
			s_nxt.pat = 16'h0000;
		end
		// Change flags: a new change wins over a clear in the same cycle.
		s_nxt.prev = {blue_status, yel_status};
		s_nxt.flags = (s_r.flags & ~clr) | set; // RULE14
		s_nxt.irq = |(s_r.flags & s_r.irq_en); // RULE14
		// Register writes take effect at the completing access edge.
		if (wr) begin
			case (paddr)
				OFS_IRQ_EN: s_nxt.irq_en = pwdata[1:0];
				OFS_FORMAT: s_nxt.fmt = pwdata[2:0]; // RULE18
				OFS_YEL_DECL: s_nxt.ydth = pwdata[7:0]; // RULE11
				OFS_YEL_CLR: s_nxt.ycth = pwdata[7:0]; // RULE12
				OFS_BLUE_DECL: s_nxt.bdth = pwdata[7:0]; // RULE15
				OFS_BLUE_CLR: s_nxt.bcth = pwdata[7:0]; // RULE15
				default: s_nxt.fmt = s_nxt.fmt;
			endcase
		end
		// Answer prepared in setup so it is ready in the first access cycle.
		s_nxt.pready = setup;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h00000000;
		if (setup) begin
			case (paddr)
				OFS_STATUS: s_nxt.prdata = {29'h0, rx_sync, blue_status,
					yel_status};
				OFS_FLAGS: s_nxt.prdata = {30'h0, s_r.flags};
				OFS_IRQ_EN: s_nxt.prdata = {30'h0, s_r.irq_en};
				OFS_FORMAT: s_nxt.prdata = {29'h0, s_r.fmt};
				OFS_YEL_DECL: s_nxt.prdata = {24'h0, s_r.ydth};
				OFS_YEL_CLR: s_nxt.prdata = {24'h0, s_r.ycth};
				OFS_BLUE_DECL: s_nxt.prdata = {24'h0, s_r.bdth};
				OFS_BLUE_CLR: s_nxt.prdata = {24'h0, s_r.bcth};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
	end

	// State register with asynchronous reset to constants.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.fmt <= FMT_RST;
			s_r.ydth <= THRESH_RST;
			s_r.ycth <= THRESH_RST;
			s_r.bdth <= THRESH_RST;
			s_r.bcth <= THRESH_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Yellow filter only sees windows that stayed aligned.
	window_persist u_yel (
		.pclk(pclk),
		.presetn(presetn),
		.restart(fmt_wr),
		.win_end(s_r.win_end && s_r.yel_win),
		.cond_declare(s_r.yel_cond),
		.declare_th(s_r.ydth),
		.clear_th(s_r.ycth),
		.status(yel_status)
	);

	// Blue filter sees every window.
	window_persist u_blue (
		.pclk(pclk),
		.presetn(presetn),
		.restart(1'b0),
		.win_end(s_r.win_end),
		.cond_declare(s_r.blue_cond),
		.declare_th(s_r.bdth),
		.clear_th(s_r.bcth),
		.status(blue_status)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A completed write of one to the yellow flag.
	sequence w1c_yel_s;
		psel && penable && pready && pwrite && paddr == OFS_FLAGS
		&& pwdata[BIT_YEL];
	endsequence

	// A setup cycle followed by its access cycle.
	sequence apb_xfer_s;
		psel && !penable ##1 psel && penable;
	endsequence

	chk_irq_level: assert property ( // RULE14
		|(s_r.flags & s_r.irq_en) |=> irq)
	else $error("interrupt missing for enabled flag");

	chk_irq_quiet: assert property ( // RULE14
		!(|(s_r.flags & s_r.irq_en)) |=> !irq)
	else $error("interrupt raised without enabled flag");

	chk_flag_on_change: assert property ( // RULE14
		$changed(yel_status) |=> s_r.flags[BIT_YEL])
	else $error("yellow change did not set flag");

	chk_flag_w1c: assert property ( // RULE14
		w1c_yel_s and (yel_status == s_r.prev[BIT_YEL])
		|=> !s_r.flags[BIT_YEL])
	else $error("yellow flag not cleared by write of one");

	chk_window_wrap: assert property ( // RULE17
		s_r.win_end |-> s_r.win_cnt == '0 ##1 !s_r.win_end)
	else $error("window boundary out of place");

	chk_yel_sync: assert property ( // RULE16
		!rx_sync |=> !s_r.yel_ok)
	else $error("yellow window kept while out of sync");

	chk_fmt_restart: assert property ( // RULE18
		fmt_wr |=> s_r.yel_cnt == 8'h00 && !s_r.yel_ok && !s_r.yel_win)
	else $error("format change did not restart yellow");

	chk_blue_verdict: assert property ( // RULE9 RULE10
		s_r.win_end |-> s_r.blue_cond == ($past(s_r.blue_cnt) < 8'h3d))
	else $error("blue window verdict wrong");

	chk_dm_verdict: assert property ( // RULE3 RULE4
		s_r.win_end && $past(s_r.fmt) == FMT_T1_DM
		|-> s_r.yel_cond == ($past(s_r.yel_cnt) < 8'h04))
	else $error("T1 DM yellow verdict wrong");

	chk_apb_ready: assert property (
		apb_xfer_s |-> pready ##1 !pready)
	else $error("APB answer not in first access cycle");
endmodule

// ### core/window_persist.sv
// Persistence filter that turns per-window verdicts into an alarm state.
`timescale 1ns/100ps
module window_persist (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic win_end,
	input wire logic cond_declare,
	input wire logic [7:0] declare_th,
	input wire logic [7:0] clear_th,
	output logic status
);
	import alarm_pkg::*;

	// Run length of windows that argue for a state change, and the state.
	typedef struct packed {
		logic [7:0] run;
		logic status;
	} persist_t;

	persist_t s_r;
	persist_t s_nxt;
	logic hit;
	logic [7:0] th;
	logic reach;

	assign status = s_r.status;

	// A window hits when its verdict opposes the present alarm state.
	// A threshold of zero acts as one, so a single window is enough.
	always_comb begin
		s_nxt = s_r;
		hit = (cond_declare != s_r.status);
		th = s_r.status ? clear_th : declare_th; // RULE11 RULE12
		reach = ({1'b0, s_r.run} + 9'h001) >= {1'b0, th};
		if (restart) begin
			s_nxt.run = 8'h00;
		end else if (win_end) begin
			if (!hit) begin
				// A failing window breaks the run.
				s_nxt.run = 8'h00; // RULE17
			end else if (reach) begin
				s_nxt.status = ~s_r.status;
				s_nxt.run = 8'h00;
			end else begin
				s_nxt.run = s_r.run + 8'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_run_cleared: assert property ( // RULE17
		win_end && !restart && (cond_declare == s_r.status)
		|=> s_r.run == 8'h00 && $stable(s_r.status))
	else $error("persistence run not cleared by failing window");

	chk_state_hold: assert property ( // RULE17
		!win_end |=> $stable(s_r.status))
	else $error("alarm state moved between windows");

	chk_declare_count: assert property ( // RULE11
		win_end && !restart && !s_r.status && cond_declare
		&& ({1'b0, s_r.run} + 9'h001 >= {1'b0, declare_th})
		|=> s_r.status)
	else $error("alarm not declared after threshold windows");
endmodule

// ### inc/alarm_pkg.sv
// Shared constants for the T1/J1 yellow and blue alarm detector.
package alarm_pkg;
	// Clock period and the fixed measurement window, both in nanoseconds.
	localparam int CLK_PERIOD_NS = 10;
	localparam int WINDOW_NS = 40_000_000;
	// Window length in clock cycles, rounded down.
	localparam int WINDOW_CYC = WINDOW_NS / CLK_PERIOD_NS;

	// Frame format codes held in the format register.
	localparam logic [2:0] FMT_T1_SF = 3'h0;
	localparam logic [2:0] FMT_T1_ESF = 3'h1;
	localparam logic [2:0] FMT_T1_DM = 3'h2;
	localparam logic [2:0] FMT_J1_SF = 3'h3;
	localparam logic [2:0] FMT_J1_ESF = 3'h4;

	// Positions of the observed bits inside the frame.
	localparam logic [3:0] SF_YEL_BIT = 4'h2;
	localparam logic [4:0] DM_YEL_CHAN = 5'h18;
	localparam logic [3:0] DM_YEL_BIT = 4'h6;
	localparam logic [4:0] J1SF_YEL_FRAME = 5'h0c;

	// Counting limits of the per-window criteria.
	localparam logic [15:0] ESF_YEL_PATTERN = 16'hff00;
	localparam logic [7:0] ESF_PAT_MAX_CLEAR = 8'h07;
	localparam logic [7:0] DM_ONES_MIN = 8'h04;
	localparam logic [7:0] J1SF_ZEROS_MIN = 8'h04;
	localparam logic [7:0] J1ESF_ZEROS_MIN = 8'h03;
	localparam logic [7:0] BLUE_ZEROS_MIN = 8'h3d;

	// APB byte offsets of the registers.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN = 8'h08;
	localparam logic [7:0] OFS_FORMAT = 8'h0c;
	localparam logic [7:0] OFS_YEL_DECL = 8'h10;
	localparam logic [7:0] OFS_YEL_CLR = 8'h14;
	localparam logic [7:0] OFS_BLUE_DECL = 8'h18;
	localparam logic [7:0] OFS_BLUE_CLR = 8'h1c;

	// Bit positions in status, flag and enable registers.
	localparam int BIT_YEL = 0;
	localparam int BIT_BLUE = 1;

	// Values after reset.
	localparam logic [7:0] THRESH_RST = 8'h01;
	localparam logic [2:0] FMT_RST = FMT_T1_SF;
endpackage

// ### sim/line_source.sv
// Remote terminal model that feeds received line bits to the detector.
`timescale 1ns/100ps
module line_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic [1:0] mode,
	output logic rx_valid,
	output logic rx_data,
	output logic rx_fbit,
	output logic rx_dl,
	output logic [4:0] rx_chan,
	output logic [3:0] rx_bitnum,
	output logic [4:0] rx_frame
);
	// Bit position on the line, one bit each cycle.
	logic [7:0] pos_r;

	// The position runs free so that channels and bits keep cycling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_r <= 8'h00;
		end else begin
			pos_r <= pos_r + 8'h01;
		end
	end

	// Two channels of eight bits alternate, channel 1 and channel 24, so
	// the channel-24 Y bit shows up sixteen times in 256 bits.
	// The last bit of each channel is a framing bit of frame 12 and a
	// link bit; mode 3 marks every bit as a link bit.
	assign rx_valid = enable;
	assign rx_bitnum = {1'b0, pos_r[2:0]} + 4'h1;
	assign rx_chan = pos_r[3] ? 5'h18 : 5'h01;
	assign rx_frame = 5'h0c;
	assign rx_fbit = (pos_r[2:0] == 3'h7);
	assign rx_dl = (mode == 2'h3) || (pos_r[2:0] == 3'h7);

	// Mode 0 sends ones, mode 1 zeros, mode 2 zeros on bit 2 only, and
	// mode 3 eight ones then eight zeros over and over.
	// A stopped line toggles so a stale value is never mistaken for data.
	always_comb begin
		if (!enable) begin
			rx_data = pos_r[0];
		end else begin
			case (mode)
				2'h0: rx_data = 1'b1;
				2'h1: rx_data = 1'b0;
				2'h2: rx_data = (rx_bitnum != 4'h2);
				default: rx_data = ~pos_r[3];
			endcase
		end
	end
endmodule

// ### sim/test_t1_yellow_blue_alarm_detect.sv
// Self-checking bench for the yellow and blue alarm detector.
`timescale 1ns/100ps
module test_t1_yellow_blue_alarm_detect;
	import alarm_pkg::*;
	// A short window keeps the run brief, yet holds over seven patterns.
	localparam int WIN = 256;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic rx_sync = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rx_valid, rx_data, rx_fbit, rx_dl;
	logic [4:0] rx_chan, rx_frame;
	logic [3:0] rx_bitnum;
	logic yellow_alarm_status, blue_alarm_status, irq;
	logic [1:0] mode = 2'h1;
	logic [31:0] rd;
	logic er;
	int error_cnt = 0;
	int tests_run = 0;

	// Free running clock of 10 ns.
	always #5 pclk = ~pclk;

	t1_yellow_blue_alarm_detect #(.WINDOW_CYCLES(WIN))
	t1_yellow_blue_alarm_detect_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_fbit(rx_fbit), .rx_dl(rx_dl), .rx_chan(rx_chan),
		.rx_bitnum(rx_bitnum), .rx_frame(rx_frame), .rx_sync(rx_sync),
		.yellow_alarm_status(yellow_alarm_status),
		.blue_alarm_status(blue_alarm_status), .irq(irq));

	line_source line_source_inst (.pclk(pclk), .presetn(presetn),
		.enable(presetn), .mode(mode), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_fbit(rx_fbit), .rx_dl(rx_dl),
		.rx_chan(rx_chan), .rx_bitnum(rx_bitnum), .rx_frame(rx_frame));

	// Prints the counts and the verdict, then ends the run.
	task print_verdict;
		$display("Compared %0d, mismatched %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the answer is taken at the rising edge that
	// samples pready high, and the request is released at that edge.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		logic done;
		done = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20 && !done; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				rd = prdata;
				er = pslverr;
				done = 1'b1;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!done) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h expected %h", $time, 1'b0, 1'b1);
			print_verdict;
		end
	endtask

	// Waits a bounded number of rising edges for an output: 0 yellow,
	// 1 blue, 2 irq; it returns on an edge so stimulus follows in step.
	task wait_sig(input int sel, input logic val, input int n);
		int i;
		logic v;
		logic ok;
		ok = 1'b0;
		for (i = 0; i < n && !ok; i++) begin
			@(posedge pclk);
			v = (sel == 0) ? yellow_alarm_status :
				(sel == 1) ? blue_alarm_status : irq;
			ok = (v === val);
		end
		tests_run++;
		if (!ok) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h expected %h", $time, v, val);
			print_verdict;
		end
	endtask

	// Reset values, read-only status and an unmapped offset.
	task test_regs;
		apb(1'b1, OFS_STATUS, 32'h3);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h4);
		apb(1'b0, OFS_YEL_DECL, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_YEL_CLR, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_BLUE_DECL, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_BLUE_CLR, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFS_FORMAT, 32'h0);
		check(rd, {29'h0, FMT_RST});
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, er}, 32'h1);
		$display("test_regs finished");
	endtask

	// Blue needs three bad windows; its change raises irq, a write of one to its flag drops it.
	task test_blue;
		apb(1'b1, OFS_BLUE_DECL, 32'h3);
		apb(1'b1, OFS_FLAGS, 32'h3);
		apb(1'b1, OFS_IRQ_EN, 32'h2);
		mode <= 2'h0;
		repeat (WIN) @(posedge pclk);
		@(negedge pclk);
		check({31'h0, blue_alarm_status}, 32'h0);
		wait_sig(1, 1'b1, 3 * WIN);
		wait_sig(2, 1'b1, 10);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check(rd & 32'h2, 32'h2);
		apb(1'b1, OFS_FLAGS, 32'h2);
		wait_sig(2, 1'b0, 10);
		mode <= 2'h1;
		wait_sig(1, 1'b0, 2 * WIN + 4);
		$display("test_blue finished");
	endtask

	// T1 SF bit 2 watching, held off while the frame is unaligned.
	task test_yellow_sf;
		mode <= 2'h1;
		wait_sig(0, 1'b1, 3 * WIN);
		mode <= 2'h0;
		wait_sig(0, 1'b0, 3 * WIN);
		rx_sync <= 1'b0;
		mode <= 2'h2;
		repeat (4 * WIN) @(posedge pclk);
		@(negedge pclk);
		check({31'h0, yellow_alarm_status}, 32'h0);
		@(posedge pclk);
		rx_sync <= 1'b1;
		wait_sig(0, 1'b1, 3 * WIN);
		$display("test_yellow_sf finished");
	endtask

	// J1 ESF link bit zeros clear and then link bit ones declare the yellow alarm.
	task test_yellow_j1esf;
		apb(1'b1, OFS_FORMAT, {29'h0, FMT_J1_ESF});
		mode <= 2'h1;
		wait_sig(0, 1'b0, 3 * WIN);
		@(posedge pclk);
		mode <= 2'h0;
		wait_sig(0, 1'b1, 3 * WIN);
		$display("test_yellow_j1esf finished");
	endtask

	// T1 DM: ones on the channel-24 Y bit clear, none declare.
	task test_yellow_dm;
		apb(1'b1, OFS_FORMAT, {29'h0, FMT_T1_DM});
		mode <= 2'h0;
		wait_sig(0, 1'b0, 3 * WIN);
		mode <= 2'h1;
		wait_sig(0, 1'b1, 3 * WIN);
		$display("test_yellow_dm finished");
	endtask

	// J1 SF: frame-12 zeros clear only after two windows; ones declare.
	task test_yellow_j1sf;
		apb(1'b1, OFS_YEL_CLR, 32'h2);
		apb(1'b1, OFS_FORMAT, {29'h0, FMT_J1_SF});
		mode <= 2'h1;
		// One clear window alone must not drop the alarm.
		repeat (2 * WIN) @(posedge pclk);
		check({31'h0, yellow_alarm_status}, 32'h1);
		wait_sig(0, 1'b0, 2 * WIN);
		mode <= 2'h0;
		wait_sig(0, 1'b1, 3 * WIN);
		$display("test_yellow_j1sf finished");
	endtask

	// T1 ESF: no link patterns clear, a steady stream of them declares.
	task test_yellow_t1esf;
		apb(1'b1, OFS_FORMAT, {29'h0, FMT_T1_ESF});
		mode <= 2'h0;
		wait_sig(0, 1'b0, 4 * WIN);
		mode <= 2'h3;
		wait_sig(0, 1'b1, 3 * WIN);
		$display("test_yellow_t1esf finished");
	endtask

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_regs;
		test_blue;
		test_yellow_sf;
		test_yellow_j1esf;
		test_yellow_dm;
		test_yellow_j1sf;
		test_yellow_t1esf;
		print_verdict;
	end
endmodule
